// *** rtl/power_mode_pkg.sv ***
package power_mode_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int PIN_WAKE_MIN_NS = 1500000;
    // Pin must stay high strictly longer than the minimum
    localparam int PIN_WAKE_CYCLES = (PIN_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int STROBE_WIDTH_NS = 200000;
    localparam int STROBE_WIDTH_CYCLES = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_PERIOD_NS = 10000000;
    localparam int STROBE_PERIOD_CYCLES = STROBE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CAL_CYCLES = 64;
    localparam logic [4:0] PSAVE_MAX_S = 5'h1b;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] PSAVE_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BYP_LSB = 2;
    localparam int CTRL_OSC_BIT = 4;
    localparam int CTRL_SLEEP_BIT = 5;
    localparam int STAT_PS_LSB = 0;
    localparam int STAT_MODE_LSB = 3;
    localparam int STAT_IDLE_BIT = 5;
    localparam logic [1:0] BYPASS_RESET = 2'h0;
    localparam logic [4:0] PSAVE_RESET = 5'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {op_normal, op_bypass, op_cal, op_test} op_mode_type;
    // Bypass flavours, valid only while in bypass mode
    typedef enum logic [1:0] {byp_full_pc, byp_datapath, byp_rf, loop_pc} bypass_type;
    typedef enum logic [2:0] {ps_sleep_ext, ps_sleep_int, ps_listen, ps_wake, ps_tx, ps_rx}
        power_state_type;

    typedef struct packed {
        logic regulators;
        logic xtal;
        logic protocol_controller;
        logic strobe_osc;
        logic wake_lna_det;
        logic tx_chain;
        logic rx_chain;
        logic register_if;
    } power_en_type;

endpackage

// *** rtl/transceiver_power_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module transceiver_power_mode_control
    import power_mode_pkg::*;
#(
    parameter int PIN_WAKE = PIN_WAKE_CYCLES,
    parameter int SECOND = SECOND_CYCLES,
    parameter int STROBE_PERIOD = STROBE_PERIOD_CYCLES,
    parameter int STROBE_WIDTH = STROBE_WIDTH_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Wakeup inputs
    input wire logic wakeup_enable_pin,
    input wire logic wake_detect,
    // Protocol controller activity
    input wire logic tx_active,
    input wire logic rx_active,
    // Block control
    output power_en_type power_en,
    output op_mode_type op_mode,
    output bypass_type bypass_sel,
    output logic bypass_active,
    output power_state_type power_state,
    output logic idle_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    power_state_type ps_q;
    op_mode_type op_mode_q;
    bypass_type bypass_q;
    logic osc_sel_q;
    logic [4:0] psave_s_q;
    logic [4:0] psave_left_q;
    logic psave_run_q;
    logic [31:0] sec_cnt_q;
    logic [31:0] pin_cnt_q;
    logic [31:0] osc_cnt_q;
    logic [7:0] cal_cnt_q;
    logic idle_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic awake;
    logic asleep;
    logic strobe;
    logic osc_strobe;
    logic wr_en;
    logic sleep_cmd;
    logic sec_tick;
    logic pin_long;
    logic tx_end;
    logic radio_wake;
    logic osc_next;

    function automatic logic [31:0] next_wrap(input logic [31:0] c, input int limit);
        next_wrap = (c >= 32'(limit - 1)) ? 32'h0 : c + 32'h1;
    endfunction

    assign awake = (ps_q == ps_wake) || (ps_q == ps_tx) || (ps_q == ps_rx);
    assign asleep = (ps_q == ps_sleep_ext) || (ps_q == ps_sleep_int);
    // Accept writes only once awake; a sleeping device has no live register file
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && awake && wb_sel_i[0];
    assign sleep_cmd = wr_en && (wb_adr_i == CTRL_ADDR) && wb_dat_i[CTRL_SLEEP_BIT];
    // A detector hit counts only in listen while the strobe powers the detector
    assign radio_wake = (ps_q == ps_listen) && strobe && wake_detect;
    // Sleep target follows a strobe select written in the same cycle as the sleep request
    assign osc_next = (wr_en && wb_adr_i == CTRL_ADDR) ? wb_dat_i[CTRL_OSC_BIT] : osc_sel_q;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // Ack one cycle after the request, dropped after one cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end

    // Read data latched on the same edge as ack; zero while asleep or unmapped
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 32'h0;
        else if (wb_cyc_i && wb_stb_i && !ack_q)
        begin
            rdata_q <= 32'h0;
            if (awake)
            begin
                unique case (wb_adr_i)
                    CTRL_ADDR:
                    begin
                        rdata_q[CTRL_MODE_LSB +: 2] <= op_mode_q;
                        rdata_q[CTRL_BYP_LSB +: 2] <= bypass_q;
                        rdata_q[CTRL_OSC_BIT] <= osc_sel_q;
                    end
                    PSAVE_ADDR: rdata_q[4:0] <= psave_s_q;
                    STATUS_ADDR:
                    begin
                        rdata_q[STAT_PS_LSB +: 3] <= ps_q;
                        rdata_q[STAT_MODE_LSB +: 2] <= op_mode_q;
                        rdata_q[STAT_IDLE_BIT] <= idle_q;
                    end
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bypass_q <= byp_full_pc;
            osc_sel_q <= 1'b0;
            psave_s_q <= PSAVE_RESET;
        end
        else if (wr_en && wb_adr_i == CTRL_ADDR)
        begin
            bypass_q <= bypass_type'(wb_dat_i[CTRL_BYP_LSB +: 2]);
            osc_sel_q <= wb_dat_i[CTRL_OSC_BIT];
        end
        else if (wr_en && wb_adr_i == PSAVE_ADDR)
            // Clamp: longer holds are not supported
            psave_s_q <= (wb_dat_i[4:0] > PSAVE_MAX_S) ? PSAVE_MAX_S : wb_dat_i[4:0];
    end

    // ------------------------------------------------------------
    // Operating mode and calibration
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_mode_q <= op_normal;
            cal_cnt_q <= 8'h0;
        end
        else if (pin_long || radio_wake)
        begin
            op_mode_q <= op_cal;
            cal_cnt_q <= 8'h0;
        end
        else if (op_mode_q == op_cal)
        begin
            // Mode writes during calibration are ignored until it ends
            cal_cnt_q <= cal_cnt_q + 8'h1;
            if (cal_cnt_q == 8'(CAL_CYCLES - 1))
                op_mode_q <= op_normal;
        end
        else if (wr_en && wb_adr_i == CTRL_ADDR)
        begin
            // Test is accepted as written; production use only
            op_mode_q <= op_mode_type'(wb_dat_i[CTRL_MODE_LSB +: 2]);
            cal_cnt_q <= 8'h0;
        end
    end

    // ------------------------------------------------------------
    // Strobes: wakeup pin and internal oscillator
    // ------------------------------------------------------------
    // Oscillator runs only while the internal strobe is chosen and not awake (sleep or listen)
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            osc_cnt_q <= 32'h0;
        else if (power_en.strobe_osc)
            osc_cnt_q <= next_wrap(osc_cnt_q, STROBE_PERIOD);
        else
            osc_cnt_q <= 32'h0;
    end

    assign osc_strobe = power_en.strobe_osc && (osc_cnt_q < 32'(STROBE_WIDTH));
    assign strobe = wakeup_enable_pin || osc_strobe;

    // Length of the present pin pulse
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pin_cnt_q <= 32'h0;
        else if (wakeup_enable_pin && !awake)
            pin_cnt_q <= (pin_cnt_q < 32'(PIN_WAKE)) ? pin_cnt_q + 32'h1 : pin_cnt_q;
        else
            pin_cnt_q <= 32'h0;
    end

    assign pin_long = wakeup_enable_pin && !awake && (pin_cnt_q == 32'(PIN_WAKE - 1));

    // ------------------------------------------------------------
    // Power-save timer
    // ------------------------------------------------------------
    assign tx_end = (ps_q == ps_tx) && !tx_active;
    assign sec_tick = psave_run_q && (sec_cnt_q == 32'(SECOND - 1));

    // Seconds divider restarts on every load so each hold is full length
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sec_cnt_q <= 32'h0;
        else if (tx_end || !psave_run_q)
            sec_cnt_q <= 32'h0;
        else
            sec_cnt_q <= next_wrap(sec_cnt_q, SECOND);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            psave_run_q <= 1'b0;
            psave_left_q <= 5'h0;
        end
        else if (tx_end)
        begin
            psave_run_q <= 1'b1;
            psave_left_q <= psave_s_q;
        end
        else if (ps_q != ps_wake)
            psave_run_q <= psave_run_q && awake;
        else if (psave_run_q && psave_left_q == 5'h0 && !rx_active && !tx_active)
            psave_run_q <= 1'b0;
        else if (sec_tick && psave_left_q != 5'h0)
            psave_left_q <= psave_left_q - 5'h1;
    end

    // ------------------------------------------------------------
    // Power state sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ps_q <= ps_sleep_ext;
        else
        begin
            unique case (ps_q)
                ps_sleep_ext, ps_sleep_int:
                begin
                    if (pin_long)
                        ps_q <= ps_wake;
                    else if (strobe)
                        ps_q <= ps_listen;
                    else
                        ps_q <= osc_sel_q ? ps_sleep_int : ps_sleep_ext;
                end
                ps_listen:
                begin
                    if (pin_long || radio_wake)
                        ps_q <= ps_wake;
                    else if (!strobe)
                        ps_q <= osc_sel_q ? ps_sleep_int : ps_sleep_ext;
                end
                ps_wake:
                begin
                    if (tx_active)
                        ps_q <= ps_tx;
                    else if (rx_active)
                        ps_q <= ps_rx;
                    else if (sleep_cmd || psave_run_q && psave_left_q == 5'h0)
                        ps_q <= osc_next ? ps_sleep_int : ps_sleep_ext;
                end
                ps_tx: ps_q <= tx_active ? ps_tx : ps_wake;
                ps_rx: ps_q <= tx_active ? ps_tx : (rx_active ? ps_rx : ps_wake);
                default: ps_q <= ps_sleep_ext;
            endcase
        end
    end

    // Pin wakeup idles; a radio wakeup goes on to send responses
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            idle_q <= 1'b1;
        else if (pin_long)
            idle_q <= 1'b1;
        else if (radio_wake)
            idle_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Block enables per power state
    // ------------------------------------------------------------
    always_comb
    begin
        power_en = '0;
        power_en.regulators = awake;
        power_en.xtal = awake;
        power_en.protocol_controller = awake;
        power_en.register_if = awake;
        power_en.tx_chain = (ps_q == ps_tx);
        power_en.rx_chain = (ps_q == ps_rx);
        power_en.strobe_osc = osc_sel_q && !awake;
        power_en.wake_lna_det = (ps_q == ps_listen) && strobe;
    end

    assign op_mode = op_mode_q;
    assign bypass_sel = bypass_q;
    assign bypass_active = (op_mode_q == op_bypass);
    assign power_state = ps_q;
    assign idle_flag = idle_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic seen_write_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            seen_write_q <= 1'b0;
        else if (wr_en)
            seen_write_q <= 1'b1;
    end

    property p_reset_normal;
        !seen_write_q && !awake |-> op_mode_q == op_normal;
    endproperty
    a_reset_normal: assert property (p_reset_normal) else $error("mode not normal at start");

    property p_wake_cal;
        !awake ##1 awake |-> op_mode_q == op_cal;
    endproperty
    a_wake_cal: assert property (p_wake_cal) else $error("no calibration on wake");

    property p_cal_return;
        $rose(op_mode_q == op_cal) |-> ##[60:66] op_mode_q == op_normal;
    endproperty
    a_cal_return: assert property (p_cal_return) else $error("calibration did not end");

    property p_bypass_only;
        bypass_active |-> $past(op_mode_q) == op_bypass || $past(wr_en);
    endproperty
    a_bypass_only: assert property (p_bypass_only) else $error("bypass without mode");

    property p_psave_hold;
        tx_end && psave_s_q != 5'h0 && !rx_active ##1 !tx_active && !rx_active && !sleep_cmd
            |-> ps_q == ps_wake;
    endproperty
    a_psave_hold: assert property (p_psave_hold) else $error("left wake during hold");

    property p_ext_osc_off;
        ps_q == ps_sleep_ext |-> !power_en.strobe_osc && !osc_strobe;
    endproperty
    a_ext_osc_off: assert property (p_ext_osc_off) else $error("oscillator on in ext sleep");

    property p_listen_end;
        ps_q == ps_listen && !strobe && !wake_detect |=> asleep;
    endproperty
    a_listen_end: assert property (p_listen_end) else $error("listen outlived strobe");

    property p_wake_power;
        awake |-> power_en.regulators && power_en.xtal && power_en.protocol_controller;
    endproperty
    a_wake_power: assert property (p_wake_power) else $error("wake without supplies");

    property p_no_write_asleep;
        !awake |=> $stable(psave_s_q) && $stable(bypass_q);
    endproperty
    a_no_write_asleep: assert property (p_no_write_asleep) else $error("write while asleep");

    property p_tx_cause;
        ps_q == ps_tx |-> $past(tx_active);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx state without tx");

    property p_pin_wake;
        pin_long |=> ps_q == ps_wake && idle_q;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("long pin did not wake");

    property p_expire;
        ps_q == ps_wake && psave_run_q && psave_left_q == 5'h0 && !tx_active && !rx_active
            |=> asleep;
    endproperty
    a_expire: assert property (p_expire) else $error("timer expiry kept wake");

    c_pin_wake: cover property (pin_long ##1 ps_q == ps_wake);
    c_radio_wake: cover property (ps_q == ps_listen && wake_detect ##1 ps_q == ps_wake);
    c_tx_sleep: cover property (ps_q == ps_tx ##1 ps_q == ps_wake ##[1:100] asleep);

endmodule

`default_nettype wire

// *** verification/host_wake_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host side of the wakeup link
// ------------------------------------------------------------
module host_wake_model
(
    // Clock
    input wire logic mclk,
    // Wakeup link
    output logic wakeup_enable_pin,
    output logic wake_detect
);
    // Both lines idle low; a low pin is the documented resting level
    initial
    begin
        wakeup_enable_pin = 1'b0;
        wake_detect = 1'b0;
    end

    // Pin strobe held for n cycles; long pulses give a pin wake
    task automatic pin_pulse(input int n);
        @(posedge mclk);
        wakeup_enable_pin <= 1'b1;
        repeat (n) @(posedge mclk);
        wakeup_enable_pin <= 1'b0;
    endtask

    // One-cycle detector hit, as a received wake message would give
    task automatic detect_hit();
        @(posedge mclk);
        wake_detect <= 1'b1;
        @(posedge mclk);
        wake_detect <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** verification/tb_transceiver_power_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_transceiver_power_mode_control;
    import power_mode_pkg::*;
    localparam int PW = 20;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pin;
    logic det;
    logic tx_active = 1'b0;
    logic rx_active = 1'b0;
    power_en_type pe;
    op_mode_type om;
    bypass_type bs;
    logic ba;
    power_state_type ps;
    logic idle;
    logic [31:0] rd;
    int fail_count = 0;
    int checks = 0;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    always #25 mclk = ~mclk;

    host_wake_model u_host (.mclk(mclk), .wakeup_enable_pin(pin), .wake_detect(det));

    // Short counts keep the run small; expectations use the same values
    transceiver_power_mode_control #(.PIN_WAKE(PW), .SECOND(10), .STROBE_PERIOD(40),
        .STROBE_WIDTH(5)) u_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wakeup_enable_pin(pin), .wake_detect(det), .tx_active(tx_active),
        .rx_active(rx_active), .power_en(pe), .op_mode(om), .bypass_sel(bs),
        .bypass_active(ba), .power_state(ps), .idle_flag(idle));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1)
                break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20)
        begin
            check(1'b0, 1'b1, "bus ack timeout");
            tally_and_finish();
        end
    endtask

    // Bounded wait for a power state; running out ends the run
    task automatic wait_state(input power_state_type s, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge mclk);
            if (ps === s)
                return;
        end
        check(32'(ps), 32'(s), "power state wait timeout");
        tally_and_finish();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(32'(ps), 32'(ps_sleep_ext), "reset state");
        check(32'(om), 32'(op_normal), "reset mode");
        check(32'(pe), 32'h0, "reset power enables");
        check(32'(idle), 32'h1, "reset idle");
        wb(1'b1, CTRL_ADDR, 32'h1);
        wb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'h0, "asleep read");
        check(32'(om), 32'(op_normal), "asleep write ignored");
        $display("reset test done");
    endtask

    task automatic t_pin_wake();
        fork
            u_host.pin_pulse(PW + 2);
        join_none
        wait_state(ps_listen, 5);
        check(32'(pe.wake_lna_det), 32'h1, "detector on with strobe");
        wait_state(ps_wake, PW + 5);
        check(32'(pe), 32'he1, "wake power enables");
        check(32'(om), 32'(op_cal), "calibration on wake");
        check(32'(idle), 32'h1, "pin wake idles");
        repeat (60) @(posedge mclk);
        check(32'(om), 32'(op_cal), "calibration too short");
        repeat (8) @(posedge mclk);
        check(32'(om), 32'(op_normal), "calibration end");
        $display("pin wake test done");
    endtask

    task automatic t_modes();
        for (int b = 0; b < 4; b++)
        begin
            wb(1'b1, CTRL_ADDR, 32'((b << CTRL_BYP_LSB) | 1));
            @(posedge mclk);
            check(32'(bs), 32'(b), "bypass flavour");
            check(32'(ba), 32'h1, "bypass active");
        end
        wb(1'b1, CTRL_ADDR, 32'h3);
        wb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'(ps_wake) | (32'(op_test) << STAT_MODE_LSB) | (32'h1 << STAT_IDLE_BIT),
            "test mode status");
        wb(1'b1, CTRL_ADDR, 32'h0);
        @(posedge mclk);
        check(32'(ba), 32'h0, "bypass off");
        $display("mode test done");
    endtask

    task automatic t_tx();
        wb(1'b1, PSAVE_ADDR, 32'h1f);
        wb(1'b0, PSAVE_ADDR, 32'h0);
        check(rd, 32'(PSAVE_MAX_S), "hold clamp");
        wb(1'b1, PSAVE_ADDR, 32'h2);
        rx_active <= 1'b1;
        wait_state(ps_rx, 4);
        check(32'(pe.rx_chain), 32'h1, "rx chain");
        rx_active <= 1'b0;
        wait_state(ps_wake, 4);
        tx_active <= 1'b1;
        wait_state(ps_tx, 4);
        check(32'(pe.tx_chain), 32'h1, "tx chain");
        tx_active <= 1'b0;
        wait_state(ps_wake, 4);
        repeat (15) @(posedge mclk);
        check(32'(ps), 32'(ps_wake), "hold after tx");
        wait_state(ps_sleep_ext, 12);
        check(32'(pe), 32'h0, "external strobe sleep");
        $display("transmit test done");
    endtask

    task automatic t_int();
        t_pin_wake();
        wb(1'b1, CTRL_ADDR, 32'h30);
        wait_state(ps_sleep_int, 4);
        check(32'(pe.strobe_osc), 32'h1, "strobe oscillator on");
        check(32'(pe), 32'h10, "internal strobe sleep enables");
        // First strobe passes without a hit: back to sleep, then one period later listen again
        wait_state(ps_listen, 4);
        check(32'(pe.wake_lna_det), 32'h1, "detector on first strobe");
        wait_state(ps_sleep_int, 10);
        repeat (30) @(posedge mclk);
        check(32'(ps), 32'(ps_sleep_int), "low power between strobes");
        wait_state(ps_listen, 10);
        check(32'(pe.wake_lna_det), 32'h1, "detector on");
        u_host.detect_hit();
        wait_state(ps_wake, 4);
        check(32'(idle), 32'h0, "radio wake responds");
        $display("internal strobe test done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_pin_wake();
        t_modes();
        t_tx();
        t_int();
        tally_and_finish();
    end
endmodule

`default_nettype wire
